//--- rtl/ebac_consts.vh
// constants for the external bus area controller
`ifndef EBAC_CONSTS_VH
`define EBAC_CONSTS_VH

// register byte addresses on apb (low 12 bits decoded)
`define EBAC_OFF_BYTE   12'h000
`define EBAC_OFF_3ST    12'h004
`define EBAC_OFF_CTL    12'h008
`define EBAC_OFF_STAT   12'h00C

// reset values
`define EBAC_BYTE_RST   8'hFF
`define EBAC_3ST_RST_HI 8'hEE
`define EBAC_3ST_RST_LO 8'h0E

// control register field positions
`define EBAC_EN_BIT     7
`define EBAC_ZP_BIT     6
`define EBAC_RSV_BIT    5
`define EBAC_P9A_BIT    4
`define EBAC_EXP_BIT    3
`define EBAC_PUC_BIT    2
`define EBAC_PBC_BIT    1
`define EBAC_P12_BIT    0

// operating modes
`define EBAC_MODE_1     3'h1
`define EBAC_MODE_2     3'h2
`define EBAC_MODE_3     3'h3
`define EBAC_MODE_4     3'h4
`define EBAC_MODE_5     3'h5
`define EBAC_MODE_6     3'h6
`define EBAC_MODE_7     3'h7

// boundary upper-byte limits forced over the boundary registers while the area enable is set outside mode 2; page 0 for the zero-page option
`define EBAC_LOW_HI     8'h00
`define EBAC_TOP_HI     8'hFF
`define EBAC_PAGE0      4'h0

// on-chip port windows, four bytes each
`define EBAC_WIN_P12    20'h0FE80
`define EBAC_WIN_P9A    20'h0FE90
`define EBAC_WIN_PBC    20'h0FE94
`define EBAC_WIN_PUC    20'h0FE98
`define EBAC_WIN_EXP    20'h0FE9C

`endif

//--- rtl/ebac_bound_cmp.v
// boundary comparator for one area register
`timescale 1ns/1ps
module ebac_bound_cmp #(
   parameter INCL = 0
) (
   // compared values
   input  wire [7:0] value,
   input  wire [7:0] bound,
   // forced outcomes
   input  wire       force_lo,
   input  wire       force_hi,
   // result
   output wire       hit
);

   // inclusive compare for the first-address form, strict for last-address form
   wire above = (INCL != 0) ? (value >= bound) : (value > bound);

   // force_hi wins over force_lo; callers never raise both
   assign hit = force_hi | (~force_lo & above);

endmodule

//--- rtl/ebac_port_win.v
// match of one disabled on-chip port window
`timescale 1ns/1ps
module ebac_port_win #(
   parameter [19:0] BASE = 20'h00000
) (
   // access address
   input  wire [19:0] addr,
   // window enable from control register
   input  wire        enable,
   // result
   output wire        hit
);

   // window spans four bytes; a cleared enable hands it to the outside
   assign hit = ~enable & (addr[19:2] == BASE[19:2]);

endmodule

//--- rtl/ebac_ctrl.v
// external bus area controller with apb register slave
`timescale 1ns/1ps
`include "ebac_consts.vh"

module ebac_ctrl (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // chip configuration
   input  wire [2:0]  mode,
   input  wire        exp_max,
   input  wire        hw_standby,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // access classification request
   input  wire        acc_req,
   input  wire [19:0] acc_addr,
   input  wire        acc_onchip,
   // access classification answer
   output reg         acc_ack_r,
   output reg         acc_ext_r,
   output reg         acc_byte_r,
   output reg         acc_3st_r,
   output reg         acc_wait_ok_r
);

   // software registers
   reg  [7:0]  byte_area_boundary_r;
   reg  [7:0]  three_state_boundary_r;
   reg  [7:0]  bus_area_control_r;
   reg  [7:0]  byte_area_boundary_nxt;
   reg  [7:0]  three_state_boundary_nxt;
   reg  [7:0]  bus_area_control_nxt;
   reg         err_r;

   // mode decode
   wire mode_en_rw   = (mode == `EBAC_MODE_5) | (mode == `EBAC_MODE_6);
   wire mode_2       = (mode == `EBAC_MODE_2);
   wire mode_7       = (mode == `EBAC_MODE_7);
   wire mode_lo_3st  = (mode == `EBAC_MODE_3) | (mode == `EBAC_MODE_4) |
                       (mode == `EBAC_MODE_5);

   // apb decode
   wire [11:0] reg_off  = paddr[11:0];
   wire        setup    = psel & ~penable;
   wire        wr_stb   = psel & penable & pwrite;
   wire        hit_byte = (reg_off == `EBAC_OFF_BYTE);
   wire        hit_3st  = (reg_off == `EBAC_OFF_3ST);
   wire        hit_ctl  = (reg_off == `EBAC_OFF_CTL);
   wire        hit_stat = (reg_off == `EBAC_OFF_STAT);
   wire        hit_any  = hit_byte | hit_3st | hit_ctl | hit_stat;

   // control fields
   wire ctl_en   = bus_area_control_r[`EBAC_EN_BIT];
   wire ctl_zp   = bus_area_control_r[`EBAC_ZP_BIT];
   wire en_p9a   = bus_area_control_r[`EBAC_P9A_BIT];
   wire en_exp   = bus_area_control_r[`EBAC_EXP_BIT];
   wire en_puc   = bus_area_control_r[`EBAC_PUC_BIT];
   wire en_pbc   = bus_area_control_r[`EBAC_PBC_BIT];
   wire en_p12   = bus_area_control_r[`EBAC_P12_BIT];

   // control register as software sees it
   wire [7:0] ctl_view;

   // bit 5 is not stored; it always reads back as one
   assign ctl_view = {bus_area_control_r[7:6], 1'b1, bus_area_control_r[4:0]};

   // zero wait state slave; registered read data is ready at the access phase
   assign pready  = 1'b1;

   // unmapped offsets answer with an error in the access phase
   assign pslverr = psel & penable & err_r;

   // next value of the byte boundary register
   always @* begin
      byte_area_boundary_nxt = byte_area_boundary_r;
      if (wr_stb & hit_byte) begin
         byte_area_boundary_nxt = pwdata[7:0];
      end
   end

   // next value of the three-state boundary register
   always @* begin
      three_state_boundary_nxt = three_state_boundary_r;
      if (wr_stb & hit_3st) begin
         three_state_boundary_nxt = pwdata[7:0];
      end
   end

   // next value of the control register with per-mode write protection
   always @* begin
      bus_area_control_nxt = bus_area_control_r;
      if (wr_stb & hit_ctl) begin
         bus_area_control_nxt[`EBAC_ZP_BIT] = pwdata[`EBAC_ZP_BIT];
         // enable bit is only writable in modes 5 and 6
         if (mode_en_rw) begin
            bus_area_control_nxt[`EBAC_EN_BIT] = pwdata[`EBAC_EN_BIT];
         end
         // mode 7 has no outside space, so the port bits stay set
         if (!mode_7) begin
            bus_area_control_nxt[4:0] = pwdata[4:0];
         end
      end
      // read-only enable in modes 1 to 4 and 7 cannot be cleared
      if (!mode_en_rw) begin
         bus_area_control_nxt[`EBAC_EN_BIT] = 1'b1;
      end
      bus_area_control_nxt[`EBAC_RSV_BIT] = 1'b0;
   end

   // register file; hardware standby reloads like reset, software standby keeps
   always @(posedge ref_clk) begin
      if (rst | hw_standby) begin
         byte_area_boundary_r <= `EBAC_BYTE_RST;
         // mode is a strap level seen at the reset edge
         if (mode_lo_3st) begin
            three_state_boundary_r <= `EBAC_3ST_RST_LO;
         end else begin
            three_state_boundary_r <= `EBAC_3ST_RST_HI;
         end
         // enable bit reset depends on mode, zero-page clear, ports set
         bus_area_control_r <= {~mode_en_rw, 1'b0, 1'b0, 5'h1F};
      end else begin
         byte_area_boundary_r   <= byte_area_boundary_nxt;
         three_state_boundary_r <= three_state_boundary_nxt;
         bus_area_control_r     <= bus_area_control_nxt;
      end
   end

   // last classification kept for the status register
   reg last_ext_r;
   reg last_byte_r;
   reg last_3st_r;

   // read data and error are captured in the setup cycle
   always @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
         err_r  <= 1'b0;
      end else if (setup) begin
         err_r  <= ~hit_any;
         prdata <= 32'h00000000;
         if (!pwrite) begin
            case (1'b1)
               hit_byte: begin
                  prdata <= {24'h000000, byte_area_boundary_r};
               end
               hit_3st: begin
                  prdata <= {24'h000000, three_state_boundary_r};
               end
               hit_ctl: begin
                  prdata <= {24'h000000, ctl_view};
               end
               hit_stat: begin
                  prdata <= {21'h00000, mode, 4'h0,
                             last_ext_r, last_byte_r, last_3st_r, ctl_en};
               end
               default: begin
                  prdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // upper address byte picked by the address space size
   wire [7:0] addr_hi;
   assign addr_hi = exp_max ? acc_addr[19:12] : acc_addr[15:8];

   // the forced areas: lowest 16-bit block and highest three-state block
   wire in_low;
   wire in_top;
   wire in_page0;
   assign in_low   = (addr_hi == `EBAC_LOW_HI);
   assign in_top   = (addr_hi == `EBAC_TOP_HI);
   assign in_page0 = (acc_addr[19:16] == `EBAC_PAGE0);

   // boundary compare results
   wire byte_hit;
   wire slow_hit;

   // strict compare: boundary value is still word width
   ebac_bound_cmp #(
      .INCL     (0)
   ) u_byte_cmp (
      .value    (addr_hi),
      .bound    (byte_area_boundary_r),
      .force_lo (in_low),
      .force_hi (1'b0),
      .hit      (byte_hit)
   );

   // inclusive compare: boundary value is the first slow address
   ebac_bound_cmp #(
      .INCL     (1)
   ) u_slow_cmp (
      .value    (addr_hi),
      .bound    (three_state_boundary_r),
      .force_lo (1'b0),
      .force_hi (in_top),
      .hit      (slow_hit)
   );

   // port windows handed to the outside when their enable is cleared
   wire [4:0] win_hit;

   ebac_port_win #(.BASE(`EBAC_WIN_P12)) u_win_p12 (
      .addr   (acc_addr),
      .enable (en_p12),
      .hit    (win_hit[0])
   );

   ebac_port_win #(.BASE(`EBAC_WIN_PBC)) u_win_pbc (
      .addr   (acc_addr),
      .enable (en_pbc),
      .hit    (win_hit[1])
   );

   ebac_port_win #(.BASE(`EBAC_WIN_PUC)) u_win_puc (
      .addr   (acc_addr),
      .enable (en_puc),
      .hit    (win_hit[2])
   );

   ebac_port_win #(.BASE(`EBAC_WIN_EXP)) u_win_exp (
      .addr   (acc_addr),
      .enable (en_exp),
      .hit    (win_hit[3])
   );

   ebac_port_win #(.BASE(`EBAC_WIN_P9A)) u_win_p9a (
      .addr   (acc_addr),
      .enable (en_p9a),
      .hit    (win_hit[4])
   );

   // classification of the current access
   wire port_out = |win_hit;
   reg  cls_ext;
   reg  cls_byte;
   reg  cls_3st;

   // decided from the live registers on every request, no cached result
   always @* begin
      cls_ext  = ~acc_onchip | port_out;
      cls_byte = 1'b0;
      cls_3st  = 1'b0;
      if (!cls_ext) begin
         // on-chip areas keep their own 16-bit two-state timing
         cls_byte = 1'b0;
         cls_3st  = 1'b0;
      end else if (port_out) begin
         cls_byte = 1'b1;
         cls_3st  = 1'b1;
      end else if (mode_2) begin
         cls_byte = 1'b1;
         cls_3st  = 1'b1;
      end else if (!ctl_en) begin
         cls_byte = 1'b1;
         cls_3st  = 1'b1;
      end else begin
         cls_byte = byte_hit;
         // zero-page option overrides the boundary inside page 0
         cls_3st  = slow_hit | (ctl_zp & in_page0);
      end
   end

   // answer registered one cycle after the request
   always @(posedge ref_clk) begin
      if (rst) begin
         acc_ack_r     <= 1'b0;
         acc_ext_r     <= 1'b0;
         acc_byte_r    <= 1'b0;
         acc_3st_r     <= 1'b0;
         acc_wait_ok_r <= 1'b0;
      end else begin
         acc_ack_r <= acc_req;
         if (acc_req) begin
            acc_ext_r     <= cls_ext;
            acc_byte_r    <= cls_byte;
            acc_3st_r     <= cls_3st;
            // wait states are only allowed in three-state cycles
            acc_wait_ok_r <= cls_ext & cls_3st;
         end
      end
   end

   // status copy of the last answer
   always @(posedge ref_clk) begin
      if (rst) begin
         last_ext_r  <= 1'b0;
         last_byte_r <= 1'b0;
         last_3st_r  <= 1'b0;
      end else if (acc_req) begin
         last_ext_r  <= cls_ext;
         last_byte_r <= cls_byte;
         last_3st_r  <= cls_3st;
      end
   end

endmodule

//--- test/ebac_ctrl_asserts.sv
// concurrent checks on the bus area controller ports
`timescale 1ns/1ps
module ebac_ctrl_asserts (
   // clock and reset
   input wire        ref_clk,
   input wire        rst,
   // configuration
   input wire [2:0]  mode,
   input wire        exp_max,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire [31:0] prdata,
   input wire        pslverr,
   // classification
   input wire        acc_req,
   input wire [19:0] acc_addr,
   input wire        acc_onchip,
   input wire        acc_ack_r,
   input wire        acc_ext_r,
   input wire        acc_byte_r,
   input wire        acc_3st_r,
   input wire        acc_wait_ok_r
);
   // upper address byte as exp_max picks it; enable bit is fixed at 1 in these modes
   wire [7:0] hi       = exp_max ? acc_addr[19:12] : acc_addr[15:8];
   wire       en_fixed = (mode != 3'h5) && (mode != 3'h6);
   wire       ext_req  = acc_req && !acc_onchip;
   wire       ctl_rd   = psel && penable && !pwrite && (paddr[11:0] == 12'h008);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_ACK_NEXT: assert property (acc_req |=> acc_ack_r) else $error("no ack after request");
   AST_HOLD: assert property (!acc_req |=> !acc_ack_r && $stable({acc_ext_r, acc_byte_r, acc_3st_r}))
      else $error("answer moved without request");
   AST_ONCHIP: assert property (acc_req && acc_onchip && acc_addr[19:5] != 15'h07F4
      |=> !acc_ext_r && !acc_byte_r && !acc_3st_r) else $error("on-chip access altered");
   AST_NO_WAIT: assert property (acc_ack_r && !acc_3st_r |-> !acc_wait_ok_r)
      else $error("wait allowed in two-state area");
   AST_MODE_TWO: assert property (ext_req && mode == 3'h2 |=> acc_byte_r && acc_3st_r)
      else $error("mode two not byte three-state");
   AST_LOW_WORD: assert property (ext_req && en_fixed && mode != 3'h2 && hi == 8'h00
      |=> !acc_byte_r) else $error("lowest range not word wide");
   AST_TOP_SLOW: assert property (ext_req && en_fixed && hi == 8'hFF |=> acc_3st_r)
      else $error("top range not three-state");
   AST_RSV_ONE: assert property (ctl_rd |-> prdata[5]) else $error("reserved bit not one");
   AST_EN_RO: assert property (ctl_rd && en_fixed |-> prdata[7])
      else $error("enable bit reads zero");

   // main scenarios reached
   cover property (ext_req && mode == 3'h2);
   cover property (acc_ack_r && acc_byte_r && !acc_3st_r);
   cover property (psel && penable && pwrite);
endmodule

//--- test/ebac_cpu_model.sv
// requester model that issues accesses for classification
`timescale 1ns/1ps
module ebac_cpu_model (
   // clock and answer
   input  wire        ref_clk,
   input  wire        acc_ack_r,
   // request
   output reg         acc_req,
   output reg  [19:0] acc_addr,
   output reg         acc_onchip
);
   // idle values at time zero
   initial begin
      acc_req = 1'b0;
      acc_addr = 20'h00000;
      acc_onchip = 1'b0;
   end

   // one request; released lines show inverted data so stale values cannot pass
   task issue(input [19:0] a, input o);
      integer n;
      begin
         @(posedge ref_clk);
         acc_req <= 1'b1;
         acc_addr <= a;
         acc_onchip <= o;
         @(posedge ref_clk);
         acc_req <= 1'b0;
         acc_addr <= ~a;
         acc_onchip <= ~o;
         #1;
         n = 0;
         while (acc_ack_r !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
         end
      end
   endtask
endmodule

//--- test/tb.sv
// self-checking bench for the bus area controller
`timescale 1ns/1ps
`include "ebac_consts.vh"
module tb;
   reg         ref_clk, rst, hw_standby, exp_max, psel, penable, pwrite;
   reg  [2:0]  mode;
   reg  [31:0] paddr, pwdata, rdv;
   reg         err;
   wire [31:0] prdata;
   wire        pready, pslverr, acc_req, acc_onchip, acc_ack_r;
   wire        acc_ext_r, acc_byte_r, acc_3st_r, acc_wait_ok_r;
   wire [19:0] acc_addr;
   integer     mismatches, total_checks;

   ebac_ctrl uut (.ref_clk(ref_clk), .rst(rst), .mode(mode), .exp_max(exp_max),
      .hw_standby(hw_standby), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acc_req(acc_req), .acc_addr(acc_addr), .acc_onchip(acc_onchip),
      .acc_ack_r(acc_ack_r), .acc_ext_r(acc_ext_r), .acc_byte_r(acc_byte_r),
      .acc_3st_r(acc_3st_r), .acc_wait_ok_r(acc_wait_ok_r));
   ebac_cpu_model cpu (.ref_clk(ref_clk), .acc_ack_r(acc_ack_r), .acc_req(acc_req),
      .acc_addr(acc_addr), .acc_onchip(acc_onchip));

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task results;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task apb(input [11:0] a, input w, input [7:0] d);
      begin
         @(posedge ref_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {20'h00000, a};
         pwdata <= {24'h000000, d};
         @(posedge ref_clk);
         penable <= 1'b1;
         do @(posedge ref_clk); while (pready !== 1'b1);
         rdv = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input [11:0] a, input [7:0] d);
      apb(a, 1'b1, d);
   endtask

   task rd(input [11:0] a, input [7:0] e);
      begin
         apb(a, 1'b0, 8'h00);
         chk(rdv, {24'h000000, e});
      end
   endtask

   // expected answer packed as ack, ext, byte, three-state, wait allowed
   task cls(input [19:0] a, input o, input [3:0] e);
      begin
         cpu.issue(a, o);
         chk({acc_ack_r, acc_ext_r, acc_byte_r, acc_3st_r, acc_wait_ok_r},
             {27'h0000000, 1'b1, e});
      end
   endtask

   // mode straps change only under reset, held five cycles
   task rst_dut(input [2:0] m, input mx);
      begin
         @(posedge ref_clk);
         mode <= m;
         exp_max <= mx;
         rst <= 1'b1;
         repeat (5) @(posedge ref_clk);
         rst <= 1'b0;
         @(posedge ref_clk);
      end
   endtask

   // hang guard, far beyond the roughly 120 cycles of the sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches = mismatches + 1;
      results;
   end

   // main sequence
   initial begin
      mismatches = 0; total_checks = 0; rst = 1'b1; hw_standby = 1'b0; exp_max = 1'b1;
      mode = 3'h3; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 0; pwdata = 0;
      rst_dut(`EBAC_MODE_3, 1'b1);
      rd(`EBAC_OFF_BYTE, 8'hFF);
      rd(`EBAC_OFF_3ST, 8'h0E);
      rd(`EBAC_OFF_CTL, 8'hBF);
      wr(`EBAC_OFF_CTL, 8'h00);
      rd(`EBAC_OFF_CTL, 8'hA0);
      cls(20'h0FE80, 1'b1, 4'hF);
      cls(20'h0FE90, 1'b1, 4'hF);
      cls(20'h0FE9C, 1'b1, 4'hF);
      wr(`EBAC_OFF_CTL, 8'hFF);
      wr(`EBAC_OFF_BYTE, 8'h40);
      wr(`EBAC_OFF_3ST, 8'h80);
      cls(20'h40FFF, 1'b0, 4'h8);
      cls(20'h41000, 1'b0, 4'hC);
      cls(20'h00500, 1'b0, 4'hB);
      cls(20'h7F000, 1'b0, 4'hC);
      cls(20'h80000, 1'b0, 4'hF);
      cls(20'hFF000, 1'b0, 4'hF);
      cls(20'h40000, 1'b1, 4'h0);
      wr(`EBAC_OFF_BYTE, 8'h00);
      cls(20'h00800, 1'b0, 4'hB);
      // status: mode 3, last answer external three-state word, enable set
      apb(`EBAC_OFF_STAT, 1'b0, 8'h00);
      chk(rdv, 32'h0000030B);
      apb(12'h010, 1'b0, 8'h00);
      chk({31'h0, err}, 1);
      chk(rdv, 0);
      @(posedge ref_clk) hw_standby <= 1'b1;
      @(posedge ref_clk) hw_standby <= 1'b0;
      rd(`EBAC_OFF_BYTE, 8'hFF);
      rd(`EBAC_OFF_3ST, 8'h0E);
      rst_dut(`EBAC_MODE_5, 1'b0);
      rd(`EBAC_OFF_CTL, 8'h3F);
      cls(20'h01234, 1'b0, 4'hF);
      wr(`EBAC_OFF_CTL, 8'hBF);
      rd(`EBAC_OFF_CTL, 8'hBF);
      cls(20'h00E00, 1'b0, 4'hB);
      cls(20'h00D00, 1'b0, 4'h8);
      cls(20'h00050, 1'b0, 4'h8);
      cls(20'h0FF00, 1'b0, 4'hB);
      rst_dut(`EBAC_MODE_2, 1'b1);
      rd(`EBAC_OFF_3ST, 8'hEE);
      cls(20'h12345, 1'b0, 4'hF);
      rst_dut(`EBAC_MODE_7, 1'b1);
      wr(`EBAC_OFF_CTL, 8'h00);
      rd(`EBAC_OFF_CTL, 8'hBF);
      results;
   end
endmodule

bind ebac_ctrl ebac_ctrl_asserts chk_i (.ref_clk(ref_clk), .rst(rst), .mode(mode),
   .exp_max(exp_max), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pslverr(pslverr), .acc_req(acc_req), .acc_addr(acc_addr),
   .acc_onchip(acc_onchip), .acc_ack_r(acc_ack_r), .acc_ext_r(acc_ext_r),
   .acc_byte_r(acc_byte_r), .acc_3st_r(acc_3st_r), .acc_wait_ok_r(acc_wait_ok_r));
